// ==== core/ccd_pkg.sv ====
// constants and types shared by the call/clear/complement/decrement executor
package ccd_pkg;
    localparam int INSTR_W     = 14;
    localparam int PC_W        = 13;
    localparam int DATA_W      = 8;
    localparam int FILE_ADDR_W = 7;
    localparam int IMM_W       = 11;
    localparam int LATCH_W     = 8;
    localparam int LATCH_HI_W  = 2;

    // field positions inside the instruction word
    localparam int IMM_MSB  = 10;
    localparam int DEST_BIT = 7;
    localparam int FILE_MSB = 6;
    localparam int OPC3_LSB = 11;
    localparam int OPC6_LSB = 8;
    localparam int OPC7_LSB = 7;

    // field positions inside the upper latch
    localparam int LATCH_HI_MSB = 4;
    localparam int LATCH_HI_LSB = 3;

    // opcode patterns
    localparam logic [2:0]  OPC_CALL      = 3'h4;
    localparam logic [2:0]  OPC_JUMP      = 3'h5;
    localparam logic [6:0]  OPC_CLEAR_REG = 7'h03;
    localparam logic [13:0] OPC_CLEAR_ACC = 14'h0103;
    localparam logic [13:0] OPC_KICK      = 14'h0064;
    localparam logic [5:0]  OPC_INVERT    = 6'h09;
    localparam logic [5:0]  OPC_DECREMENT = 6'h03;
    localparam logic        DEST_ACC      = 1'b0;

    // reset and constant values
    localparam logic [12:0] PC_RST    = 13'h0000;
    localparam logic [12:0] PC_STEP   = 13'h0001;
    localparam logic [7:0]  BYTE_ZERO = 8'h00;
    localparam logic [7:0]  BYTE_ONE  = 8'h01;
    localparam logic [7:0]  BYTE_FULL = 8'hff;
    localparam logic        FLAG_SET  = 1'b1;
    localparam logic        FLAG_CLR  = 1'b0;

    typedef enum logic [2:0] {
        OP_OTHER,
        OP_CALL,
        OP_JUMP,
        OP_CLEAR_REG,
        OP_CLEAR_ACC,
        OP_KICK,
        OP_INVERT,
        OP_DECREMENT
    } ccd_op_t;

    typedef enum logic {
        ST_EXEC,
        ST_FLUSH
    } ccd_state_t;
endpackage

// ==== core/ccd_exec.sv ====
// execution slice: call, jump, clears, watchdog kick, complement, decrement
`timescale 1ns/1ps
`default_nettype none

module ccd_exec (
    input  wire logic                             clk_i,
    input  wire logic                             rst_b_i,
    input  wire logic                             ce_i,
    input  wire logic                             instr_valid_i,
    input  wire logic [ccd_pkg::INSTR_W-1:0]      instr_i,
    input  wire logic [ccd_pkg::DATA_W-1:0]       file_rdata_i,
    input  wire logic [ccd_pkg::LATCH_W-1:0]      program_counter_upper_latch_i,
    input  wire logic                             watchdog_tick_i,
    input  wire logic                             sleep_enter_i,
    output logic      [ccd_pkg::PC_W-1:0]         pc_o,
    output logic                                  busy_o,
    output logic                                  stack_push_o,
    output logic      [ccd_pkg::PC_W-1:0]         return_stack_head_o,
    output logic      [ccd_pkg::DATA_W-1:0]       acc_o,
    output logic                                  zero_flag_o,
    output logic                                  file_wr_en_o,
    output logic      [ccd_pkg::FILE_ADDR_W-1:0]  file_addr_o,
    output logic      [ccd_pkg::DATA_W-1:0]       file_wdata_o,
    output logic      [ccd_pkg::DATA_W-1:0]       watchdog_counter_o,
    output logic      [ccd_pkg::DATA_W-1:0]       watchdog_prescaler_o,
    output logic                                  timer_expiry_flag_o,
    output logic                                  sleep_entry_flag_o
);

    // opcode decode
    function automatic ccd_pkg::ccd_op_t decode_op(input logic [ccd_pkg::INSTR_W-1:0] ins);
        ccd_pkg::ccd_op_t op;
        op = ccd_pkg::OP_OTHER;
        if (ins[ccd_pkg::INSTR_W-1:ccd_pkg::OPC3_LSB] == ccd_pkg::OPC_CALL)
            op = ccd_pkg::OP_CALL;
        else if (ins[ccd_pkg::INSTR_W-1:ccd_pkg::OPC3_LSB] == ccd_pkg::OPC_JUMP)
            op = ccd_pkg::OP_JUMP;
        else if (ins == ccd_pkg::OPC_CLEAR_ACC)
            op = ccd_pkg::OP_CLEAR_ACC;
        else if (ins == ccd_pkg::OPC_KICK)
            op = ccd_pkg::OP_KICK;
        else if (ins[ccd_pkg::INSTR_W-1:ccd_pkg::OPC7_LSB] == ccd_pkg::OPC_CLEAR_REG)
            op = ccd_pkg::OP_CLEAR_REG;
        else if (ins[ccd_pkg::INSTR_W-1:ccd_pkg::OPC6_LSB] == ccd_pkg::OPC_INVERT)
            op = ccd_pkg::OP_INVERT;
        else if (ins[ccd_pkg::INSTR_W-1:ccd_pkg::OPC6_LSB] == ccd_pkg::OPC_DECREMENT)
            op = ccd_pkg::OP_DECREMENT;
        return op;
    endfunction

    // all-zero test on a byte
    function automatic logic is_zero(input logic [ccd_pkg::DATA_W-1:0] val);
        return val == ccd_pkg::BYTE_ZERO;
    endfunction

    ccd_pkg::ccd_state_t              state_r;
    ccd_pkg::ccd_state_t              state_nxt;
    ccd_pkg::ccd_op_t                 op;
    logic [ccd_pkg::PC_W-1:0]         pc_r;
    logic [ccd_pkg::PC_W-1:0]         pc_inc;
    logic [ccd_pkg::PC_W-1:0]         branch_target;
    logic [ccd_pkg::IMM_W-1:0]        imm;
    logic [ccd_pkg::LATCH_HI_W-1:0]   latch_hi;
    logic [ccd_pkg::FILE_ADDR_W-1:0]  file_addr;
    logic                             dest_bit;
    logic [ccd_pkg::DATA_W-1:0]       dec_val;
    logic [ccd_pkg::DATA_W-1:0]       alu_val;
    logic                             alu_zero;
    logic                             take;
    logic                             take_call;
    logic                             take_jump;
    logic                             take_clear_reg;
    logic                             take_clear_acc;
    logic                             take_kick;
    logic                             take_invert;
    logic                             take_decrement;
    logic                             take_alu;
    logic                             presc_wrap;
    logic                             count_wrap;
    logic                             file_wr;

    // operand fields
    assign imm           = instr_i[ccd_pkg::IMM_MSB:0];
    assign latch_hi      = program_counter_upper_latch_i[ccd_pkg::LATCH_HI_MSB:
                                                         ccd_pkg::LATCH_HI_LSB];
    assign branch_target = {latch_hi, imm};
    assign file_addr     = instr_i[ccd_pkg::FILE_MSB:0];
    assign dest_bit      = instr_i[ccd_pkg::DEST_BIT];
    assign pc_inc        = pc_r + ccd_pkg::PC_STEP;

    // data path
    assign dec_val  = file_rdata_i - ccd_pkg::BYTE_ONE;
    assign alu_val  = take_invert ? ~file_rdata_i : dec_val;
    assign alu_zero = is_zero(alu_val);

    // issue qualification
    assign op             = decode_op(instr_i);
    assign take           = ce_i && instr_valid_i && (state_r == ccd_pkg::ST_EXEC);
    assign take_call      = take && (op == ccd_pkg::OP_CALL);
    assign take_jump      = take && (op == ccd_pkg::OP_JUMP);
    assign take_clear_reg = take && (op == ccd_pkg::OP_CLEAR_REG);
    assign take_clear_acc = take && (op == ccd_pkg::OP_CLEAR_ACC);
    assign take_kick      = take && (op == ccd_pkg::OP_KICK);
    assign take_invert    = take && (op == ccd_pkg::OP_INVERT);
    assign take_decrement = take && (op == ccd_pkg::OP_DECREMENT);
    assign take_alu       = take_invert || take_decrement;
    assign file_wr        = take_clear_reg || (take_alu && (dest_bit != ccd_pkg::DEST_ACC));

    // watchdog roll-over
    assign presc_wrap = watchdog_tick_i && (watchdog_prescaler_o == ccd_pkg::BYTE_FULL);
    assign count_wrap = presc_wrap && (watchdog_counter_o == ccd_pkg::BYTE_FULL);

    // flush state after a branch
    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            ccd_pkg::ST_EXEC:
            begin
                if (take_call || take_jump)
                    state_nxt = ccd_pkg::ST_FLUSH;
            end
            ccd_pkg::ST_FLUSH:
            begin
                state_nxt = ccd_pkg::ST_EXEC;
            end
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            state_r <= ccd_pkg::ST_EXEC;
            busy_o  <= 1'b0;
        end
        else if (ce_i)
        begin
            state_r <= state_nxt;
            busy_o  <= (state_nxt == ccd_pkg::ST_FLUSH);
        end
    end

    // program counter
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
            pc_r <= ccd_pkg::PC_RST;
        else if (take_call || take_jump)
            pc_r <= branch_target;
        else if (take)
            pc_r <= pc_inc;
    end

    assign pc_o = pc_r;

    // return stack head
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            stack_push_o        <= 1'b0;
            return_stack_head_o <= ccd_pkg::PC_RST;
        end
        else if (ce_i)
        begin
            stack_push_o <= take_call;
            if (take_call)
                return_stack_head_o <= pc_inc;
        end
    end

    // accumulator
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
            acc_o <= ccd_pkg::BYTE_ZERO;
        else if (take_clear_acc)
            acc_o <= ccd_pkg::BYTE_ZERO;
        else if (take_alu && (dest_bit == ccd_pkg::DEST_ACC))
            acc_o <= alu_val;
    end

    // zero flag, untouched by branches
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
            zero_flag_o <= ccd_pkg::FLAG_CLR;
        else if (take_clear_reg || take_clear_acc)
            zero_flag_o <= ccd_pkg::FLAG_SET;
        else if (take_alu)
            zero_flag_o <= alu_zero;
    end

    // file register write port
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            file_wr_en_o <= 1'b0;
            file_addr_o  <= '0;
            file_wdata_o <= ccd_pkg::BYTE_ZERO;
        end
        else if (ce_i)
        begin
            file_wr_en_o <= file_wr;
            if (take_clear_reg || take_alu)
                file_addr_o <= file_addr;
            if (file_wr)
                file_wdata_o <= take_clear_reg ? ccd_pkg::BYTE_ZERO : alu_val;
        end
    end

    // watchdog counter and prescaler
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            watchdog_counter_o   <= ccd_pkg::BYTE_ZERO;
            watchdog_prescaler_o <= ccd_pkg::BYTE_ZERO;
        end
        else if (take_kick)
        begin
            watchdog_counter_o   <= ccd_pkg::BYTE_ZERO;
            watchdog_prescaler_o <= ccd_pkg::BYTE_ZERO;
        end
        else if (ce_i && watchdog_tick_i)
        begin
            watchdog_prescaler_o <= watchdog_prescaler_o + ccd_pkg::BYTE_ONE;
            if (presc_wrap)
                watchdog_counter_o <= watchdog_counter_o + ccd_pkg::BYTE_ONE;
        end
    end

    // status flags, kick wins over any clear
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            timer_expiry_flag_o <= ccd_pkg::FLAG_SET;
            sleep_entry_flag_o  <= ccd_pkg::FLAG_SET;
        end
        else if (take_kick)
        begin
            timer_expiry_flag_o <= ccd_pkg::FLAG_SET;
            sleep_entry_flag_o  <= ccd_pkg::FLAG_SET;
        end
        else if (ce_i)
        begin
            if (count_wrap)
                timer_expiry_flag_o <= ccd_pkg::FLAG_CLR;
            if (sleep_enter_i)
                sleep_entry_flag_o <= ccd_pkg::FLAG_CLR;
        end
    end

    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    AST_CALL_PUSH: assert property (
        take_call |=> stack_push_o && (return_stack_head_o == $past(pc_inc)))
        else $error("call did not push pc plus one");

    AST_CALL_LOW: assert property (
        take_call |=> pc_o[ccd_pkg::IMM_MSB:0] == $past(imm))
        else $error("call low pc bits wrong");

    AST_CALL_HIGH: assert property (
        take_call |=> pc_o[ccd_pkg::PC_W-1:ccd_pkg::IMM_W] == $past(latch_hi))
        else $error("call high pc bits wrong");

    AST_CALL_TWO: assert property (
        take_call |=> busy_o && $stable(zero_flag_o) && $stable(timer_expiry_flag_o))
        else $error("call not two cycles or flags moved");

    AST_FLUSH_END: assert property (
        (busy_o && ce_i) |=> !busy_o && $stable(pc_o))
        else $error("flush cycle did not end");

    AST_CLEAR_REG: assert property (
        take_clear_reg |=> file_wr_en_o && is_zero(file_wdata_o) && zero_flag_o)
        else $error("clear_reg wrong");

    AST_CLEAR_ACC: assert property (
        take_clear_acc |=> is_zero(acc_o) && zero_flag_o && !busy_o && !file_wr_en_o)
        else $error("clear_accumulator wrong");

    AST_KICK: assert property (
        take_kick |=> is_zero(watchdog_counter_o) && is_zero(watchdog_prescaler_o))
        else $error("kick did not clear watchdog");

    AST_KICK_FLAGS: assert property (
        take_kick |=> timer_expiry_flag_o && sleep_entry_flag_o)
        else $error("kick did not set flags");

    AST_INVERT: assert property (
        (take_invert && dest_bit) |=> file_wr_en_o && (file_wdata_o == ~$past(file_rdata_i)))
        else $error("invert result wrong");

    AST_DEST_ACC: assert property (
        (take_alu && !dest_bit) |=> !file_wr_en_o && (acc_o == $past(alu_val)))
        else $error("accumulator destination wrong");

    AST_DEC: assert property (
        (take_decrement && dest_bit) |=> file_wdata_o == $past(dec_val))
        else $error("decrement result wrong");

    AST_DEC_KEEP: assert property (
        (take_decrement && !dest_bit) |=> !file_wr_en_o && $stable(file_wdata_o))
        else $error("decrement touched source");

    AST_ADDR: assert property (
        (take_clear_reg || take_alu) |=> file_addr_o == $past(file_addr))
        else $error("file address wrong");

    AST_ZERO: assert property (
        take_alu |=> zero_flag_o == is_zero($past(alu_val)))
        else $error("zero flag wrong");

    AST_SINGLE: assert property (
        (take_clear_reg || take_alu || take_kick) |=> !busy_o && (pc_o == $past(pc_inc)))
        else $error("single-cycle op stalled");

    AST_JUMP: assert property (
        take_jump |=> busy_o && !stack_push_o && (pc_o == $past(branch_target)))
        else $error("jump wrong");

    COV_CALL: cover property (take_call ##1 busy_o ##1 !busy_o);
    COV_DEC_ACC: cover property (take_decrement && !dest_bit);
    COV_KICK: cover property (take_kick);
    COV_CLEAR_REG: cover property (take_clear_reg ##1 take_invert);

endmodule

`default_nettype wire

// ==== testbench/ccd_exec_tb.sv ====
// self-checking bench for the call/clear/complement/decrement executor
`timescale 1ns/1ps
`default_nettype none

module ccd_exec_tb;
    logic        clk_i                         = 1'b0;
    logic        rst_b_i                       = 1'b0;
    logic        ce_i                          = 1'b1;
    logic        instr_valid_i                 = 1'b0;
    logic [13:0] instr_i                       = 14'h0000;
    logic [7:0]  file_rdata_i                  = 8'h00;
    logic [7:0]  program_counter_upper_latch_i = 8'h00;
    logic        watchdog_tick_i               = 1'b0;
    logic        sleep_enter_i                 = 1'b0;
    logic [12:0] pc_o;
    logic        busy_o;
    logic        stack_push_o;
    logic [12:0] return_stack_head_o;
    logic [7:0]  acc_o;
    logic        zero_flag_o;
    logic        file_wr_en_o;
    logic [6:0]  file_addr_o;
    logic [7:0]  file_wdata_o;
    logic [7:0]  watchdog_counter_o;
    logic [7:0]  watchdog_prescaler_o;
    logic        timer_expiry_flag_o;
    logic        sleep_entry_flag_o;
    logic [12:0] p;
    logic [12:0] h;
    int          n_fail   = 0;
    int          n_checks = 0;

    ccd_exec ccd_exec_i (
        .clk_i, .rst_b_i, .ce_i, .instr_valid_i, .instr_i, .file_rdata_i,
        .program_counter_upper_latch_i, .watchdog_tick_i, .sleep_enter_i,
        .pc_o, .busy_o, .stack_push_o, .return_stack_head_o, .acc_o, .zero_flag_o,
        .file_wr_en_o, .file_addr_o, .file_wdata_o, .watchdog_counter_o,
        .watchdog_prescaler_o, .timer_expiry_flag_o, .sleep_entry_flag_o
    );

    always #12.5 clk_i = ~clk_i;

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [12:0] exp, input logic [12:0] got);
        n_checks++;
        if (got !== exp)
        begin
            $display("mismatch %s expected %h seen %h", nm, exp, got);
            n_fail++;
        end
    endtask

    function automatic logic [13:0] fop(input logic [5:0] op, input logic d, input logic [6:0] f);
        return {op, d, f};
    endfunction

    // present one instruction at the next edge
    task automatic send(input logic [13:0] w, input logic [7:0] d);
        @(posedge clk_i);
        instr_valid_i <= 1'b1;
        instr_i       <= w;
        file_rdata_i  <= d;
    endtask

    task automatic idle();
        @(posedge clk_i);
        instr_valid_i <= 1'b0;
        #1;
    endtask

    task automatic t_reset();
        #1;
        chk("pc", 13'h0000, pc_o);
        chk("busy", 13'h0000, busy_o);
        chk("zero", 13'h0000, zero_flag_o);
        chk("expiry", 13'h0001, timer_expiry_flag_o);
        chk("sleep", 13'h0001, sleep_entry_flag_o);
    endtask

    task automatic t_invert();
        p = pc_o;
        send(fop(ccd_pkg::OPC_INVERT, 1'b0, 7'h05), 8'h13);
        send(fop(ccd_pkg::OPC_INVERT, 1'b1, 7'h7f), 8'hff);
        #1;
        chk("acc", 13'h00ec, acc_o);
        chk("wr_en", 13'h0000, file_wr_en_o);
        chk("zero", 13'h0000, zero_flag_o);
        chk("pc", p + 13'h0001, pc_o);
        idle();
        chk("wr_en", 13'h0001, file_wr_en_o);
        chk("addr", 13'h007f, file_addr_o);
        chk("wdata", 13'h0000, file_wdata_o);
        chk("zero", 13'h0001, zero_flag_o);
        chk("acc", 13'h00ec, acc_o);
        chk("pc", p + 13'h0002, pc_o);
    endtask

    task automatic t_decrement();
        send(fop(ccd_pkg::OPC_DECREMENT, 1'b1, 7'h00), 8'h01);
        send(fop(ccd_pkg::OPC_DECREMENT, 1'b0, 7'h22), 8'h00);
        #1;
        chk("wr_en", 13'h0001, file_wr_en_o);
        chk("addr", 13'h0000, file_addr_o);
        chk("wdata", 13'h0000, file_wdata_o);
        chk("zero", 13'h0001, zero_flag_o);
        idle();
        chk("acc", 13'h00ff, acc_o);
        chk("wr_en", 13'h0000, file_wr_en_o);
        chk("zero", 13'h0000, zero_flag_o);
    endtask

    task automatic t_clears();
        p = pc_o;
        send({ccd_pkg::OPC_CLEAR_REG, 7'h7f}, 8'h5a);
        send(fop(ccd_pkg::OPC_INVERT, 1'b0, 7'h01), 8'h00);
        #1;
        chk("wr_en", 13'h0001, file_wr_en_o);
        chk("addr", 13'h007f, file_addr_o);
        chk("wdata", 13'h0000, file_wdata_o);
        chk("zero", 13'h0001, zero_flag_o);
        chk("pc", p + 13'h0001, pc_o);
        send(ccd_pkg::OPC_CLEAR_ACC, 8'h5a);
        #1;
        chk("acc", 13'h00ff, acc_o);
        chk("zero", 13'h0000, zero_flag_o);
        idle();
        chk("acc", 13'h0000, acc_o);
        chk("zero", 13'h0001, zero_flag_o);
        chk("pc", p + 13'h0003, pc_o);
    endtask

    // clock enable low freezes every flop
    task automatic t_hold();
        p = pc_o;
        @(posedge clk_i);
        ce_i            <= 1'b0;
        watchdog_tick_i <= 1'b1;
        send(fop(ccd_pkg::OPC_INVERT, 1'b1, 7'h03), 8'h00);
        idle();
        chk("pc", p, pc_o);
        chk("wr_en", 13'h0000, file_wr_en_o);
        chk("prescaler", 13'h0000, watchdog_prescaler_o);
        ce_i            <= 1'b1;
        watchdog_tick_i <= 1'b0;
    endtask

    // call followed by an instruction in the flush slot
    task automatic t_call();
        program_counter_upper_latch_i <= 8'he9;
        p = pc_o;
        send({ccd_pkg::OPC_CALL, 11'h7ff}, 8'h00);
        send(fop(ccd_pkg::OPC_INVERT, 1'b0, 7'h01), 8'h00);
        #1;
        chk("pc", 13'h0fff, pc_o);
        chk("push", 13'h0001, stack_push_o);
        chk("head", p + 13'h0001, return_stack_head_o);
        chk("busy", 13'h0001, busy_o);
        chk("zero", 13'h0001, zero_flag_o);
        idle();
        chk("busy", 13'h0000, busy_o);
        chk("push", 13'h0000, stack_push_o);
        chk("acc", 13'h0000, acc_o);
        chk("pc", 13'h0fff, pc_o);
    endtask

    task automatic t_jump();
        program_counter_upper_latch_i <= 8'h10;
        h = return_stack_head_o;
        send({ccd_pkg::OPC_JUMP, 11'h000}, 8'h00);
        idle();
        chk("pc", 13'h1000, pc_o);
        chk("busy", 13'h0001, busy_o);
        chk("push", 13'h0000, stack_push_o);
        chk("head", h, return_stack_head_o);
        idle();
        chk("busy", 13'h0000, busy_o);
    endtask

    // watchdog runs past a wrap, then a kick lands beside a tick
    task automatic t_watchdog();
        @(posedge clk_i);
        sleep_enter_i   <= 1'b1;
        watchdog_tick_i <= 1'b1;
        @(posedge clk_i);
        sleep_enter_i <= 1'b0;
        repeat (65835) @(posedge clk_i);
        watchdog_tick_i <= 1'b0;
        #1;
        chk("sleep", 13'h0000, sleep_entry_flag_o);
        chk("prescaler", 13'h002c, watchdog_prescaler_o);
        chk("counter", 13'h0001, watchdog_counter_o);
        chk("expiry", 13'h0000, timer_expiry_flag_o);
        send(ccd_pkg::OPC_KICK, 8'h00);
        watchdog_tick_i <= 1'b1;
        sleep_enter_i   <= 1'b1;
        idle();
        watchdog_tick_i <= 1'b0;
        sleep_enter_i   <= 1'b0;
        chk("counter", 13'h0000, watchdog_counter_o);
        chk("prescaler", 13'h0000, watchdog_prescaler_o);
        chk("expiry", 13'h0001, timer_expiry_flag_o);
        chk("sleep", 13'h0001, sleep_entry_flag_o);
    endtask

    initial
    begin
        repeat (6) @(posedge clk_i);
        rst_b_i <= 1'b1;
        t_reset();
        t_invert();
        t_decrement();
        t_clears();
        t_call();
        t_jump();
        t_hold();
        t_watchdog();
        idle();
        test_done();
    end

    initial
    begin
        #(90000 * 25);
        $display("mismatch watchdog expected done seen hang");
        n_fail++;
        test_done();
    end
endmodule

`default_nettype wire
